// file: core/fef_consts.svh
// constants of the exception flagging unit: offsets, bit positions, codes
// assumes inclusion by bare name from every design file that needs them
`ifndef FEF_CONSTS_SVH
`define FEF_CONSTS_SVH

// ==========================================
// register byte offsets
`define FEF_OFF_CMD 8'h00
`define FEF_OFF_DATA 8'h04
`define FEF_OFF_RESULT 8'h08
`define FEF_OFF_STATUS 8'h0c
`define FEF_OFF_TAGS 8'h10
`define FEF_OFF_ACK 8'h14

// ==========================================
// status word bit positions
`define FEF_SW_IE 0
`define FEF_SW_DE 1
`define FEF_SW_ZE 2
`define FEF_SW_SF 6
`define FEF_SW_ES 7
`define FEF_SW_C1 9
`define FEF_NUM_EXC 6

// ==========================================
// reset values
`define FEF_CW_RST 16'h037f
`define FEF_TAGS_RST 16'hffff

// ==========================================
// tag codes
`define FEF_TAG_VALID 2'b00
`define FEF_TAG_ZERO 2'b01
`define FEF_TAG_SPECIAL 2'b10
`define FEF_TAG_EMPTY 2'b11

// ==========================================
// indefinite codes, upper word of each format
`define FEF_IND_FP 16'hffc0
`define FEF_IND_INT 16'h8000
`define FEF_IND_BCD 16'hffff

`endif

// file: core/fef_pkg.sv
// types of the exception flagging unit
// assumes nothing beyond the constants header
package fef_pkg;

    // ==========================================
    // instruction codes
    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_LD_SD = 5'h01, OP_LD_EXT = 5'h02, OP_LD_REG = 5'h03,
        OP_LD_CONST = 5'h04, OP_LD_INT = 5'h05, OP_ST_SD = 5'h06, OP_ST_EXT_P = 5'h07,
        OP_ST_REG = 5'h08, OP_ST_INT = 5'h09, OP_ST_BCD_P = 5'h0a, OP_ST_TRUNC_P = 5'h0b,
        OP_ARITH = 5'h0c, OP_UNARY = 5'h0d, OP_COMPARE = 5'h0e, OP_ABS_CHS = 5'h0f,
        OP_EXCH = 5'h10, OP_EXAMINE = 5'h11, OP_LD_CW = 5'h12, OP_ST_CW = 5'h13,
        OP_ST_SW = 5'h14, OP_CLEX = 5'h15, OP_INIT = 5'h16, OP_SAVE = 5'h17,
        OP_RESTORE = 5'h18, OP_XSAVE = 5'h19, OP_XRESTORE = 5'h1a, OP_INC_SP = 5'h1b,
        OP_DEC_SP = 5'h1c, OP_FREE = 5'h1d
    } fef_op_t;

    typedef enum logic [1:0] {
        MEM_NONE = 2'h0, MEM_FP = 2'h1, MEM_INT = 2'h2, MEM_BCD = 2'h3
    } fef_mem_t;

    // command register layout
    typedef struct packed {
        logic [14:0] rsvd;
        logic pop;
        logic [1:0] res_tag;
        logic [5:0] exc;
        logic [2:0] sti;
        fef_op_t op;
    } fef_cmd_t;

    // decoded instruction class
    typedef struct packed {
        logic arith;
        logic push;
        logic pop_always;
        logic pop_opt;
        logic use_st0;
        logic use_sti;
        logic dst_st0;
        logic dst_sti;
        logic swap;
        fef_mem_t mem;
    } fef_cls_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } fef_bus_st_t;

    // status word contents apart from the summary
    typedef struct packed {
        logic [5:0] flags;
        logic sf;
        logic [3:0] cc;
        logic [2:0] top;
    } fef_stat_t;

endpackage : fef_pkg

// file: core/fef_op_class.sv
// instruction classifier: arithmetic or not, stack use, destination
// assumes a valid code from the command register
`timescale 1ns/1ps
`default_nettype none
module fef_op_class import fef_pkg::*; (
    // instruction in
    input wire fef_op_t op_i,
    // class out
    output fef_cls_t cls_o
);
    always_comb begin
        cls_o = '0;
        case (op_i)
            OP_LD_SD, OP_LD_INT: begin
                cls_o.arith = 1'b1;
                cls_o.push = 1'b1;
            end
            OP_LD_EXT, OP_LD_CONST: cls_o.push = 1'b1;
            OP_LD_REG: begin
                cls_o.push = 1'b1;
                cls_o.use_sti = 1'b1;
            end
            OP_ST_SD, OP_ST_INT: begin
                cls_o.arith = 1'b1;
                cls_o.use_st0 = 1'b1;
                cls_o.pop_opt = 1'b1;
                cls_o.mem = (op_i == OP_ST_SD) ? MEM_FP : MEM_INT;
            end
            OP_ST_EXT_P: begin
                cls_o.use_st0 = 1'b1;
                cls_o.pop_always = 1'b1;
                cls_o.mem = MEM_FP;
            end
            OP_ST_REG: begin
                cls_o.use_st0 = 1'b1;
                cls_o.pop_opt = 1'b1;
                cls_o.dst_sti = 1'b1;
            end
            OP_ST_BCD_P, OP_ST_TRUNC_P: begin
                cls_o.arith = 1'b1;
                cls_o.use_st0 = 1'b1;
                cls_o.pop_always = 1'b1;
                cls_o.mem = (op_i == OP_ST_BCD_P) ? MEM_BCD : MEM_INT;
            end
            OP_ARITH, OP_COMPARE: begin
                cls_o.arith = 1'b1;
                cls_o.use_st0 = 1'b1;
                cls_o.use_sti = 1'b1;
                cls_o.dst_st0 = (op_i == OP_ARITH);
                cls_o.pop_opt = 1'b1;
            end
            OP_UNARY, OP_ABS_CHS: begin
                cls_o.arith = (op_i == OP_UNARY);
                cls_o.use_st0 = 1'b1;
                cls_o.dst_st0 = 1'b1;
            end
            OP_EXCH: begin
                cls_o.use_st0 = 1'b1;
                cls_o.use_sti = 1'b1;
                cls_o.swap = 1'b1;
            end
            default: cls_o = '0;
        endcase
    end
endmodule : fef_op_class
`default_nettype wire

// file: core/fef_tag_file.sv
// tag store of the eight-entry register stack, two write ports
// assumes port 1 wins when both ports hit one entry
`timescale 1ns/1ps
`default_nettype none
`include "fef_consts.svh"
module fef_tag_file #(
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // writes
    input wire logic init_i,
    input wire logic we0_i,
    input wire logic [$clog2(DEPTH)-1:0] idx0_i,
    input wire logic [1:0] tag0_i,
    input wire logic we1_i,
    input wire logic [$clog2(DEPTH)-1:0] idx1_i,
    input wire logic [1:0] tag1_i,
    // tags out
    output logic [2*DEPTH-1:0] tags_o
);
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i || init_i) begin
                    tags_o[2*g +: 2] <= `FEF_TAG_EMPTY;
                end else if (we1_i && idx1_i == g) begin
                    tags_o[2*g +: 2] <= tag1_i;
                end else if (we0_i && idx0_i == g) begin
                    tags_o[2*g +: 2] <= tag0_i;
                end
            end
        end
    endgenerate
endmodule : fef_tag_file
`default_nettype wire

// file: core/fef_core.sv
// exception flagging unit: status and control words, stack fault detection
// assumes an avalon-mm master issuing instructions through the command register
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "fef_consts.svh"
module fef_core import fef_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // handler and status view
    output logic handler_req_o,
    output logic [15:0] status_word_o
);
    localparam int IW = $clog2(DEPTH);

    // ==========================================
    // state
    fef_bus_st_t bus_st_q;
    fef_stat_t stat_q, stat_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [31:0] data_q;
    logic [31:0] result_q, result_d;
    logic [2*DEPTH-1:0] tags;
    fef_cmd_t cmd;
    fef_cls_t cls;

    // ==========================================
    // helpers
    function automatic logic [1:0] tag_at(input logic [2*DEPTH-1:0] t,
                                          input logic [IW-1:0] i);
        tag_at = t[2*i +: 2];
    endfunction : tag_at

    function automatic logic summary(input logic [5:0] f, input logic [15:0] c);
        summary = |(f & ~c[`FEF_NUM_EXC-1:0]);
    endfunction : summary

    function automatic logic [15:0] pack_sw(input fef_stat_t s, input logic [15:0] c);
        logic es;
        es = summary(s.flags, c);
        pack_sw = {es, s.cc[3], s.top, s.cc[2:0], es, s.sf, s.flags};
    endfunction : pack_sw

    function automatic fef_stat_t unpack_sw(input logic [15:0] w);
        unpack_sw.flags = w[`FEF_NUM_EXC-1:0];
        unpack_sw.sf = w[`FEF_SW_SF];
        unpack_sw.cc = {w[14], w[10:8]};
        unpack_sw.top = w[13:11];
    endfunction : unpack_sw

    // ==========================================
    // bus handshake
    logic take;
    logic take_wr;
    logic exec;
    assign take = (bus_st_q == BUS_ACK);
    assign take_wr = take && avs_write_i;
    assign exec = take_wr && avs_address_i == ADDR_W'(`FEF_OFF_CMD);
    assign cmd = fef_cmd_t'(avs_writedata_i);

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            bus_st_q <= BUS_IDLE;
            avs_waitrequest_o <= 1'b1;
        end else begin
            case (bus_st_q)
                BUS_IDLE: begin
                    if (avs_read_i || avs_write_i) begin
                        bus_st_q <= BUS_ACK;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                BUS_ACK: begin
                    bus_st_q <= BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default: begin
                    bus_st_q <= BUS_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // read data loaded while the answer is prepared
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= '0;
        end else if (bus_st_q == BUS_IDLE && avs_read_i) begin
            case (avs_address_i)
                ADDR_W'(`FEF_OFF_DATA): avs_readdata_o <= data_q;
                ADDR_W'(`FEF_OFF_RESULT): avs_readdata_o <= result_q;
                ADDR_W'(`FEF_OFF_STATUS): avs_readdata_o <= {16'h0000, status_word_o};
                ADDR_W'(`FEF_OFF_TAGS): avs_readdata_o <= 32'(tags);
                ADDR_W'(`FEF_OFF_ACK): avs_readdata_o <= {31'h0, handler_req_o};
                default: avs_readdata_o <= '0;
            endcase
        end
    end

    // operand word, byte lanes honoured
    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_data
            always_ff @(posedge ref_clk_i) begin
                if (sys_rst_i) begin
                    data_q[8*b +: 8] <= '0;
                end else if (take_wr && avs_byteenable_i[b] &&
                             avs_address_i == ADDR_W'(`FEF_OFF_DATA)) begin
                    data_q[8*b +: 8] <= avs_writedata_i[8*b +: 8];
                end
            end
        end
    endgenerate

    // ==========================================
    // classification and stack fault detection
    fef_op_class u_class (
        .op_i(cmd.op),
        .cls_o(cls)
    );

    logic [IW-1:0] idx_st0;
    logic [IW-1:0] idx_sti;
    logic [IW-1:0] idx_push;
    logic ovf;
    logic unf;
    logic fault;
    logic [5:0] exc_new;
    logic unmasked;
    logic do_pop;

    assign idx_st0 = stat_q.top;
    assign idx_sti = IW'(stat_q.top + cmd.sti);
    assign idx_push = IW'(stat_q.top - 1'b1);
    assign ovf = cls.push && tag_at(tags, idx_push) != `FEF_TAG_EMPTY;
    assign unf = (cls.use_st0 && tag_at(tags, idx_st0) == `FEF_TAG_EMPTY) ||
                 (cls.use_sti && tag_at(tags, idx_sti) == `FEF_TAG_EMPTY);
    assign fault = ovf || unf;
    assign do_pop = cls.pop_always || (cls.pop_opt && cmd.pop);

    // operand exceptions only for arithmetic instructions
    always_comb begin
        exc_new = '0;
        if (fault) begin
            exc_new[`FEF_SW_IE] = 1'b1;
        end else if (cls.arith) begin
            exc_new = cmd.exc;
        end
    end
    assign unmasked = |(exc_new & ~ctrl_q[`FEF_NUM_EXC-1:0]);

    // ==========================================
    // tag writes
    logic init;
    logic we0;
    logic we1;
    logic [IW-1:0] idx0;
    logic [IW-1:0] idx1;
    logic [1:0] tag0;
    logic [1:0] tag1;

    assign init = exec && (cmd.op == OP_INIT || cmd.op == OP_SAVE);

    always_comb begin
        we0 = 1'b0;
        we1 = 1'b0;
        idx0 = idx_st0;
        idx1 = idx_st0;
        tag0 = cmd.res_tag;
        tag1 = `FEF_TAG_EMPTY;
        if (exec && !unmasked) begin
            if (cls.push) begin
                we0 = 1'b1;
                idx0 = idx_push;
                if (fault) begin
                    tag0 = `FEF_TAG_SPECIAL;
                end else if (cmd.op == OP_LD_REG) begin
                    tag0 = tag_at(tags, idx_sti);
                end
            end else if (cls.dst_st0 || cls.dst_sti) begin
                we0 = 1'b1;
                idx0 = cls.dst_sti ? idx_sti : idx_st0;
                if (fault) begin
                    tag0 = `FEF_TAG_SPECIAL;
                end else if (cls.dst_sti) begin
                    tag0 = tag_at(tags, idx_st0);
                end
            end else if (cls.swap) begin
                we0 = 1'b1;
                we1 = 1'b1;
                idx0 = idx_sti;
                idx1 = idx_st0;
                tag0 = unf && tag_at(tags, idx_st0) == `FEF_TAG_EMPTY ?
                       `FEF_TAG_SPECIAL : tag_at(tags, idx_st0);
                tag1 = unf && tag_at(tags, idx_sti) == `FEF_TAG_EMPTY ?
                       `FEF_TAG_SPECIAL : tag_at(tags, idx_sti);
            end else if (cmd.op == OP_FREE) begin
                we0 = 1'b1;
                idx0 = idx_sti;
                tag0 = `FEF_TAG_EMPTY;
            end
            if (do_pop) begin
                we1 = 1'b1;
                idx1 = idx_st0;
                tag1 = `FEF_TAG_EMPTY;
            end
        end
    end

    fef_tag_file #(
        .DEPTH(DEPTH)
    ) u_tags (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .init_i(init),
        .we0_i(we0),
        .idx0_i(idx0),
        .tag0_i(tag0),
        .we1_i(we1),
        .idx1_i(idx1),
        .tag1_i(tag1),
        .tags_o(tags)
    );

    // ==========================================
    // status and control next state
    always_comb begin
        stat_d = stat_q;
        ctrl_d = ctrl_q;
        if (exec) begin
            case (cmd.op)
                OP_LD_CW: ctrl_d = data_q[15:0];
                OP_RESTORE, OP_XRESTORE: begin
                    ctrl_d = data_q[15:0];
                    stat_d = unpack_sw(data_q[31:16]);
                end
                OP_CLEX: begin
                    stat_d.flags = '0;
                    stat_d.sf = 1'b0;
                end
                OP_INIT, OP_SAVE: begin
                    ctrl_d = `FEF_CW_RST;
                    stat_d = '0;
                end
                OP_INC_SP: stat_d.top = IW'(stat_q.top + 1'b1);
                OP_DEC_SP: stat_d.top = IW'(stat_q.top - 1'b1);
                default: begin
                    stat_d.flags = stat_q.flags | exc_new;
                    if (fault) begin
                        stat_d.sf = 1'b1;
                        stat_d.cc[1] = ovf;
                    end
                    if (!unmasked) begin
                        if (cls.push) begin
                            stat_d.top = idx_push;
                        end else if (do_pop) begin
                            stat_d.top = IW'(stat_q.top + 1'b1);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            stat_q <= '0;
        end else begin
            stat_q <= stat_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            ctrl_q <= `FEF_CW_RST;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            status_word_o <= '0;
        end else begin
            status_word_o <= pack_sw(stat_d, ctrl_d);
        end
    end

    // ==========================================
    // stored words and indefinite results
    always_comb begin
        result_d = result_q;
        if (exec) begin
            case (cmd.op)
                OP_ST_CW: result_d = {16'h0000, ctrl_q};
                OP_ST_SW: result_d = {16'h0000, pack_sw(stat_q, ctrl_q)};
                OP_SAVE, OP_XSAVE: result_d = {pack_sw(stat_q, ctrl_q), ctrl_q};
                default: begin
                    if (fault && !unmasked) begin
                        case (cls.mem)
                            MEM_FP: result_d = {`FEF_IND_FP, 16'h0000};
                            MEM_INT: result_d = {`FEF_IND_INT, 16'h0000};
                            MEM_BCD: result_d = {`FEF_IND_BCD, 16'h0000};
                            default: result_d = result_q;
                        endcase
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            result_q <= '0;
        end else begin
            result_q <= result_d;
        end
    end

    // ==========================================
    // handler request, set beats acknowledge
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            handler_req_o <= 1'b0;
        end else if (exec && unmasked) begin
            handler_req_o <= 1'b1;
        end else if (take_wr && avs_address_i == ADDR_W'(`FEF_OFF_ACK)) begin
            handler_req_o <= 1'b0;
        end
    end

endmodule : fef_core
`default_nettype wire

// file: tb/fef_core_checker.sv
// port assertions of the exception flagging unit
// assumes a bind onto fef_core
`timescale 1ns/1ps
`default_nettype none
`include "fef_consts.svh"
module fef_core_checker #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // bus and status
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic handler_req_o,
    input wire logic [15:0] status_word_o
);
    // ==========================================
    // taken writes
    logic cmd_w;
    logic ack_w;
    assign cmd_w = avs_write_i && !avs_waitrequest_o && avs_address_i == `FEF_OFF_CMD;
    assign ack_w = avs_write_i && !avs_waitrequest_o && avs_address_i == `FEF_OFF_ACK;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ==========================================
    // properties
    a_wait_pulse: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
        else $error("waitrequest low longer than one cycle");
    a_req_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered");
    a_flags_sticky: assert property (!cmd_w |=> $stable(status_word_o[6:0]))
        else $error("flags moved without an instruction");
    a_es_mirror: assert property (status_word_o[15] == status_word_o[7])
        else $error("summary copies disagree");
    a_es_cause: assert property (status_word_o[7] |-> |status_word_o[5:0])
        else $error("summary without a flag");
    a_fault_pair: assert property ($rose(status_word_o[6]) |-> status_word_o[0])
        else $error("stack fault without invalid flag");
    a_handler_hold: assert property (handler_req_o && !ack_w |=> handler_req_o)
        else $error("handler request dropped");
    a_ack_clear: assert property (ack_w |=> !handler_req_o)
        else $error("handler request not cleared");
    a_handler_top: assert property ($rose(handler_req_o)
        |-> $stable(status_word_o[13:11])) else $error("top moved on handler call");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst_i |=> avs_waitrequest_o
        && !handler_req_o && status_word_o == 16'h0000) else $error("reset state wrong");
endmodule : fef_core_checker
bind fef_core fef_core_checker #(.ADDR_W(ADDR_W)) u_chk (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .handler_req_o(handler_req_o), .status_word_o(status_word_o));
`default_nettype wire

// file: tb/fef_host_model.sv
// issuing core: avalon-mm master with one transfer task
// assumes the slave answers with one low cycle of waitrequest
`timescale 1ns/1ps
`default_nettype none
module fef_host_model (
    // clock and answer
    input wire logic ref_clk_i,
    input wire logic avs_waitrequest_i,
    input wire logic [31:0] avs_readdata_i,
    // request
    output logic [7:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic [3:0] avs_byteenable_o
);
    initial begin
        avs_address_o = 8'h00;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h0;
        avs_byteenable_o = 4'hf;
    end
    // ==========================================
    // held until waitrequest sampled low
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
        @(posedge ref_clk_i);
        avs_address_o <= a;
        avs_writedata_o <= d;
        avs_byteenable_o <= be;
        avs_read_o <= !wr;
        avs_write_o <= wr;
        @(posedge ref_clk_i);
        while (avs_waitrequest_i) @(posedge ref_clk_i);
        q = avs_readdata_i;
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
        // let the launching edge settle before callers look at outputs
        @(negedge ref_clk_i);
    endtask : xfer
endmodule : fef_host_model
`default_nettype wire

// file: tb/fpu_exception_flagging_tb.sv
// self-checking bench of the exception flagging unit
// assumes fef_core with its bound checker and the host model
`timescale 1ns/1ps
`default_nettype none
`include "fef_consts.svh"
module fpu_exception_flagging_tb import fef_pkg::*;;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] adr;
    logic rd_s, wr_s, wait_s, hreq;
    logic [31:0] wd, rdat, rd_q, dat, rng;
    logic [3:0] be;
    logic [15:0] sw;
    logic [5:0] exp_f;
    logic [2:0] top0;
    int err_count = 0;
    int total_checks = 0;
    fef_op_t tbl[7] = '{OP_NOP, OP_ABS_CHS, OP_EXCH, OP_EXAMINE, OP_ARITH, OP_UNARY, OP_COMPARE};
    fef_op_t sto[3] = '{OP_ST_SD, OP_ST_INT, OP_ST_BCD_P};
    logic [15:0] ind[3] = '{`FEF_IND_FP, `FEF_IND_INT, `FEF_IND_BCD};
    always #12.5 ref_clk_i = !ref_clk_i;
    fef_host_model u_host (.ref_clk_i(ref_clk_i), .avs_waitrequest_i(wait_s),
        .avs_readdata_i(rdat), .avs_address_o(adr), .avs_read_o(rd_s), .avs_write_o(wr_s),
        .avs_writedata_o(wd), .avs_byteenable_o(be));
    fef_core u_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr),
        .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd), .avs_byteenable_i(be),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wait_s), .handler_req_o(hreq),
        .status_word_o(sw));
    // ==========================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] b);
        for (int k = 0; k < 4; k++) if (b[k]) o[8*k+:8] = n[8*k+:8];
        return o;
    endfunction : merge
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cmd(input fef_op_t op, input logic [2:0] i, input logic [5:0] e);
        u_host.xfer(1'b1, `FEF_OFF_CMD, {15'h0, op == OP_ST_TRUNC_P, 2'b00, e, i, op}, 4'hf, rd_q);
    endtask : cmd
    task automatic rd(input logic [7:0] a);
        u_host.xfer(1'b0, a, 32'h0, 4'hf, rd_q);
    endtask : rd
    task automatic end_sim;
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim
    // ==========================================
    // scenarios
    initial begin
        rng = 32'h00013c25;
        repeat (3) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        chk(sw, 32'h0);
        rd(`FEF_OFF_TAGS); chk(rd_q, `FEF_TAGS_RST);
        cmd(OP_ST_CW, 3'h0, 6'h0); rd(`FEF_OFF_RESULT); chk(rd_q[15:0], `FEF_CW_RST);
        rd(8'h18); chk(rd_q, 32'h0);
        rng = xs(rng); dat = rng;
        u_host.xfer(1'b1, `FEF_OFF_DATA, dat, 4'hf, rd_q);
        rng = xs(rng);
        u_host.xfer(1'b1, `FEF_OFF_DATA, rng, 4'b0101, rd_q);
        rd(`FEF_OFF_DATA); chk(rd_q, merge(dat, rng, 4'b0101));
        for (int k = 0; k < 9; k++) cmd(OP_LD_EXT, 3'h0, 6'h3f);
        chk(sw & 16'hbaff, 16'h3a41);
        rd(`FEF_OFF_TAGS); chk({hreq, rd_q[30:0]}, 32'h8000);
        cmd(OP_ARITH, 3'h1, 6'h05); chk(sw[6:0], 7'h45);
        cmd(OP_CLEX, 3'h0, 6'h0);
        exp_f = 6'h0;
        for (int n = 0; n < 24; n++) begin
            rng = xs(rng);
            cmd(tbl[rng[18:16] % 7], rng[10:8], rng[5:0]);
            if (rng[18:16] % 7 > 3) exp_f |= rng[5:0];
            chk(sw & 16'h80ff, {24'h0, 2'b00, exp_f});
        end
        cmd(OP_CLEX, 3'h0, 6'h0);
        cmd(OP_ST_TRUNC_P, 3'h0, 6'h20); chk(sw[6:0], 7'h20);
        u_host.xfer(1'b1, `FEF_OFF_DATA, 32'h037e, 4'hf, rd_q);
        cmd(OP_LD_CW, 3'h0, 6'h0);
        top0 = sw[13:11];
        cmd(OP_ARITH, 3'h1, 6'h01);
        chk({hreq, sw[15], sw[7], sw[0], sw[13:11]}, {4'hf, top0});
        rd(`FEF_OFF_ACK); chk(rd_q[0], 1'b1);
        u_host.xfer(1'b1, `FEF_OFF_ACK, 32'h0, 4'hf, rd_q); chk(hreq, 1'b0);
        cmd(OP_XSAVE, 3'h0, 6'h0); rd(`FEF_OFF_RESULT);
        chk(rd_q & 32'h0081ffff, 32'h0081037e);
        for (int k = 0; k < 3; k++) begin
            cmd(OP_SAVE, 3'h0, 6'h0);
            cmd(sto[k], 3'h0, 6'h0); chk(sw & 16'h02c1, 16'h0041);
            rd(`FEF_OFF_RESULT); chk(rd_q, {ind[k], 16'h0});
        end
        cmd(OP_ST_SW, 3'h0, 6'h0); rd(`FEF_OFF_RESULT); chk(rd_q, 32'h0841);
        u_host.xfer(1'b1, `FEF_OFF_DATA, 32'h0004037b, 4'hf, rd_q);
        cmd(OP_RESTORE, 3'h0, 6'h0); chk(sw, 32'h8084);
        rd(`FEF_OFF_STATUS); chk(rd_q, 32'h8084);
        cmd(OP_ST_CW, 3'h0, 6'h0); rd(`FEF_OFF_RESULT); chk(rd_q, 32'h037b);
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        err_count++;
        end_sim();
    end
endmodule : fpu_exception_flagging_tb
`default_nettype wire
